// file: pkg/clock_source_pkg.sv
// Register map, field layout, reset values and types of the clock source unit
package clock_source_pkg;
   localparam logic [3:0] OFS_CONTROL_1 = 4'h0;
   localparam logic [3:0] OFS_CONTROL_2 = 4'h4;
   localparam logic [3:0] OFS_TRIM = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;

   localparam int SRC_SEL_HI = 7;
   localparam int SRC_SEL_LO = 6;
   localparam int REF_DIV_HI = 5;
   localparam int REF_DIV_LO = 3;
   localparam int FLL_REF_SEL_BIT = 2;
   localparam int INT_OUT_EN_BIT = 1;
   localparam int INT_STOP_EN_BIT = 0;
   localparam int BUS_DIV_HI = 7;
   localparam int BUS_DIV_LO = 6;
   localparam int RANGE_BIT = 5;
   localparam int GAIN_BIT = 4;
   localparam int LOW_POWER_BIT = 3;
   localparam int EXT_SRC_SEL_BIT = 2;
   localparam int EXT_OUT_EN_BIT = 1;
   localparam int EXT_STOP_EN_BIT = 0;
   localparam int FINE_STEP_BIT = 0;
   localparam int STATUS_SRC_HI = 3;
   localparam int STATUS_SRC_LO = 2;

   localparam logic [7:0] CONTROL_1_RESET = 8'h04;
   localparam logic [7:0] CONTROL_2_RESET = 8'h40;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam logic FINE_STEP_RESET = 1'b0;

   localparam logic [1:0] SEL_FLL = 2'b00;
   localparam logic [1:0] SEL_INTERNAL = 2'b01;
   localparam logic [1:0] SEL_EXTERNAL = 2'b10;

   localparam int REF_COUNT_W = 7;
   localparam int BUS_COUNT_W = 3;

   // Applied source of the output multiplexer, Gray along FLL, internal, external
   typedef enum logic [1:0] {
      SRC_FLL = 2'b00,
      SRC_INT = 2'b01,
      SRC_EXT = 2'b11
   } source_e;

   typedef struct packed {
      logic high_range;
      logic high_gain;
      logic crystal;
   } osc_ctrl_s;

   typedef struct packed {
      logic internal_enable;
      logic external_enable;
      logic fll_enable;
   } clock_enable_s;
endpackage : clock_source_pkg

// file: verilog/fll_clock_source_regs.sv
// Control and trim registers of the clock source unit, with its tick-level clock path
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Source field bits 7:6 picks FLL, internal or external; code 11 acts as FLL.
// - Reference divider bits 5:3 divide FLL reference by two to the code.
// - Bit 2 set takes FLL reference from internal, clear from external.
// - Bit 1 gates the internal reference clock output.
// - Internal stop enable keeps internal reference alive in stop when enabled or used.
// - Bus divider bits 7:6 divide by 1, 2, 4, 8; reset code 01.
// - Range bit 5 selects high or low oscillator frequency range.
// - Gain bit 4 selects high gain or low power oscillator operation.
// - Low power bit stops FLL in bypass modes unless debug is active.
// - Bit 2 of second register requests crystal or external clock input.
// - Bit 1 of second register gates the external reference clock output.
// - External stop enable keeps external reference alive in stop when enabled or used.
// - Eight-bit trim sets internal period; larger value means longer period.
// - Fine step bit is the smallest period step; set lengthens it.
// - Source code 01 is internal, 10 external, FLL bypassed in both.
// - Bus clock runs at half the divided source output frequency.
// - Reset leaves the unit in FLL engaged mode on the internal reference.
module fll_clock_source_regs (
   input wire logic CLOCK, // 125 MHz system clock
   input wire logic NRST, // Asynchronous reset, active low
   input wire logic [3:0] ADDRESS, // Avalon byte address
   input wire logic READ, // Avalon read request
   input wire logic WRITE, // Avalon write request
   input wire logic [31:0] WRITEDATA, // Avalon write data
   input wire logic [3:0] BYTEENABLE, // Avalon byte enables
   output logic [31:0] READDATA, // Avalon read data
   output logic WAITREQUEST, // Avalon wait request
   input wire logic INT_REF_TICK, // Rising edge of internal reference
   input wire logic EXT_REF_TICK, // Rising edge of external reference
   input wire logic FLL_TICK, // Rising edge of FLL output
   input wire logic STOP_MODE, // Device is in stop
   input wire logic DEBUG_ACTIVE, // Background debug mode active
   output logic FLL_REFERENCE_TICK, // Divided FLL reference edge
   output logic INTERNAL_REFERENCE_OUT, // Gated internal reference edge
   output logic EXTERNAL_REFERENCE_OUT, // Gated external reference edge
   output logic SOURCE_CLOCK_OUT, // Divided source clock edge
   output logic BUS_CLOCK, // Bus clock level
   output clock_source_pkg::osc_ctrl_s OSC_CTRL, // Oscillator controls
   output clock_source_pkg::clock_enable_s CLOCK_ENABLE, // Clock generator enables
   output logic [8:0] PERIOD_TRIM // Trim code, fine step in bit 0
);
   import clock_source_pkg::*;

   logic [7:0] control_1;
   logic [7:0] control_2;
   logic [7:0] trim;
   logic fine_step;
   logic wr_ok;
   logic [1:0] sel;
   logic [2:0] ref_div;
   logic fll_ref_internal;
   logic [1:0] bus_div;
   logic low_power;
   logic int_used_before_stop;
   logic ext_used_before_stop;
   logic int_run;
   logic ext_run;
   logic ref_tick;
   logic [REF_COUNT_W-1:0] ref_count;
   logic [REF_COUNT_W-1:0] ref_limit;
   source_e source;
   logic [1:0] bus_div_applied;
   logic [BUS_COUNT_W-1:0] bus_count;
   logic [BUS_COUNT_W-1:0] bus_limit;
   logic src_tick;
   logic div_tick;

   // Source code to applied multiplexer state, reserved code falls back to FLL
   function automatic source_e decode_source(input logic [1:0] code);
      case (code)
         SEL_INTERNAL: decode_source = SRC_INT;
         SEL_EXTERNAL: decode_source = SRC_EXT;
         default: decode_source = SRC_FLL;
      endcase
   endfunction : decode_source

   // Mode runs on the internal reference: FLL engaged on it, or bypassed to it
   function automatic logic uses_internal(input logic [1:0] code, input logic fll_reference_select);
      uses_internal = (decode_source(code) == SRC_INT) ||
                      ((decode_source(code) == SRC_FLL) && fll_reference_select);
   endfunction : uses_internal

   function automatic logic uses_external(input logic [1:0] code, input logic fll_reference_select);
      uses_external = (decode_source(code) == SRC_EXT) ||
                      ((decode_source(code) == SRC_FLL) && !fll_reference_select);
   endfunction : uses_external

   assign sel = control_1[SRC_SEL_HI:SRC_SEL_LO];
   assign ref_div = control_1[REF_DIV_HI:REF_DIV_LO];
   assign fll_ref_internal = control_1[FLL_REF_SEL_BIT];
   assign bus_div = control_2[BUS_DIV_HI:BUS_DIV_LO];
   assign low_power = control_2[LOW_POWER_BIT];
   assign wr_ok = WRITE && !WAITREQUEST && BYTEENABLE[0];

   // One wait state on every access; the bus sees the answer at the second edge
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         WAITREQUEST <= 1'b1;
      end else if ((READ || WRITE) && WAITREQUEST) begin
         WAITREQUEST <= 1'b0;
      end else begin
         WAITREQUEST <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         READDATA <= 32'h0000_0000;
      end else if (READ && WAITREQUEST) begin
         case (ADDRESS)
            OFS_CONTROL_1: READDATA <= {24'h00_0000, control_1};
            OFS_CONTROL_2: READDATA <= {24'h00_0000, control_2};
            OFS_TRIM: READDATA <= {24'h00_0000, trim};
            OFS_STATUS: begin
               READDATA <= 32'h0000_0000;
               READDATA[STATUS_SRC_HI:STATUS_SRC_LO] <=
                  (source == SRC_INT) ? SEL_INTERNAL :
                  (source == SRC_EXT) ? SEL_EXTERNAL : SEL_FLL;
               READDATA[FINE_STEP_BIT] <= fine_step;
            end
            default: READDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Reset value selects FLL with internal reference: engaged internal mode
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         control_1 <= CONTROL_1_RESET;
      end else if (wr_ok && ADDRESS == OFS_CONTROL_1) begin
         control_1 <= WRITEDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         control_2 <= CONTROL_2_RESET;
      end else if (wr_ok && ADDRESS == OFS_CONTROL_2) begin
         control_2 <= WRITEDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         trim <= TRIM_RESET;
      end else if (wr_ok && ADDRESS == OFS_TRIM) begin
         trim <= WRITEDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         fine_step <= FINE_STEP_RESET;
      end else if (wr_ok && ADDRESS == OFS_STATUS) begin
         fine_step <= WRITEDATA[FINE_STEP_BIT];
      end
   end

   // Trim code goes to the oscillator as is; a larger code lengthens its period
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         PERIOD_TRIM <= {TRIM_RESET, FINE_STEP_RESET};
      end else begin
         PERIOD_TRIM <= {trim, fine_step};
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         OSC_CTRL <= '0;
      end else begin
         OSC_CTRL.high_range <= control_2[RANGE_BIT];
         OSC_CTRL.high_gain <= control_2[GAIN_BIT];
         OSC_CTRL.crystal <= control_2[EXT_SRC_SEL_BIT];
      end
   end

   // Mode in use is frozen on entry to stop, since it decides what stays alive
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         int_used_before_stop <= 1'b1;
         ext_used_before_stop <= 1'b0;
      end else if (!STOP_MODE) begin
         int_used_before_stop <= uses_internal(sel, fll_ref_internal);
         ext_used_before_stop <= uses_external(sel, fll_ref_internal);
      end
   end

   assign int_run = !STOP_MODE ||
                    (control_1[INT_STOP_EN_BIT] &&
                     (control_1[INT_OUT_EN_BIT] || int_used_before_stop));
   assign ext_run = !STOP_MODE ||
                    (control_2[EXT_STOP_EN_BIT] &&
                     (control_2[EXT_OUT_EN_BIT] || ext_used_before_stop));

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         CLOCK_ENABLE <= '0;
      end else begin
         CLOCK_ENABLE.internal_enable <= int_run &&
            (control_1[INT_OUT_EN_BIT] || STOP_MODE ||
             uses_internal(sel, fll_ref_internal));
         CLOCK_ENABLE.external_enable <= ext_run &&
            (control_2[EXT_OUT_EN_BIT] || STOP_MODE ||
             uses_external(sel, fll_ref_internal));
         // Debug keeps the FLL alive so the debug clock survives bypass modes
         CLOCK_ENABLE.fll_enable <= !STOP_MODE &&
            !(low_power && !DEBUG_ACTIVE && decode_source(sel) != SRC_FLL);
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         INTERNAL_REFERENCE_OUT <= 1'b0;
         EXTERNAL_REFERENCE_OUT <= 1'b0;
      end else begin
         INTERNAL_REFERENCE_OUT <= INT_REF_TICK && control_1[INT_OUT_EN_BIT] && int_run;
         EXTERNAL_REFERENCE_OUT <= EXT_REF_TICK && control_2[EXT_OUT_EN_BIT] && ext_run;
      end
   end

   // Reference divider counts edges of the chosen FLL reference
   assign ref_tick = fll_ref_internal ? INT_REF_TICK : EXT_REF_TICK;
   assign ref_limit = REF_COUNT_W'((1 << ref_div) - 1);

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ref_count <= '0;
         FLL_REFERENCE_TICK <= 1'b0;
      end else begin
         FLL_REFERENCE_TICK <= 1'b0;
         if (ref_tick) begin
            if (ref_count >= ref_limit) begin
               ref_count <= '0;
               FLL_REFERENCE_TICK <= !STOP_MODE;
            end else begin
               ref_count <= ref_count + 1'b1;
            end
         end
      end
   end

   always_comb begin
      case (source)
         SRC_INT: src_tick = INT_REF_TICK;
         SRC_EXT: src_tick = EXT_REF_TICK;
         SRC_FLL: src_tick = FLL_TICK;
         default: src_tick = FLL_TICK;
      endcase
   end

   assign bus_limit = BUS_COUNT_W'((1 << bus_div_applied) - 1);
   assign div_tick = src_tick && (bus_count >= bus_limit);

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         bus_count <= '0;
      end else if (div_tick) begin
         bus_count <= '0;
      end else if (src_tick) begin
         bus_count <= bus_count + 1'b1;
      end
   end

   // New selections take hold only on a completed phase; the next phase is whole
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         source <= SRC_FLL;
         bus_div_applied <= CONTROL_2_RESET[BUS_DIV_HI:BUS_DIV_LO];
      end else if (div_tick) begin
         source <= decode_source(sel);
         bus_div_applied <= bus_div;
      end
   end

   // Each divided edge toggles the bus clock, so it runs at half that rate
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         SOURCE_CLOCK_OUT <= 1'b0;
         BUS_CLOCK <= 1'b0;
      end else begin
         SOURCE_CLOCK_OUT <= div_tick && !STOP_MODE;
         if (div_tick && !STOP_MODE) begin
            BUS_CLOCK <= !BUS_CLOCK;
         end
      end
   end
endmodule : fll_clock_source_regs

// file: tb/clock_source_checker.sv
// Concurrent checks on the ports of the clock source register block
`timescale 1ns/10ps
module clock_source_checker (
   input wire logic CLOCK, // clock
   input wire logic NRST, // reset
   input wire logic READ, // read
   input wire logic WRITE, // write
   input wire logic WAITREQUEST, // wait
   input wire logic INT_REF_TICK, // tick
   input wire logic EXT_REF_TICK, // tick
   input wire logic STOP_MODE, // stop
   input wire logic DEBUG_ACTIVE, // debug
   input wire logic FLL_REFERENCE_TICK, // out
   input wire logic INTERNAL_REFERENCE_OUT, // out
   input wire logic EXTERNAL_REFERENCE_OUT, // out
   input wire logic SOURCE_CLOCK_OUT, // out
   input wire logic BUS_CLOCK, // out
   input wire clock_source_pkg::clock_enable_s CLOCK_ENABLE // out
);
   import clock_source_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   bus_wait_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("access not answered");
   wait_pulse_a: assert property (!WAITREQUEST |=> WAITREQUEST)
      else $error("wait low too long");
   int_out_a: assert property (INTERNAL_REFERENCE_OUT |-> $past(INT_REF_TICK))
      else $error("internal out without tick");
   ext_out_a: assert property (EXTERNAL_REFERENCE_OUT |-> $past(EXT_REF_TICK))
      else $error("external out without tick");
   bus_toggle_a: assert property ($changed(BUS_CLOCK) == SOURCE_CLOCK_OUT)
      else $error("bus clock toggle mismatch");
   ref_tick_a: assert property (FLL_REFERENCE_TICK |-> $past(INT_REF_TICK || EXT_REF_TICK))
      else $error("reference tick without cause");
   stop_fll_a: assert property (STOP_MODE |=> !CLOCK_ENABLE.fll_enable)
      else $error("loop running in stop");
   debug_fll_a: assert property (!STOP_MODE && DEBUG_ACTIVE |=> CLOCK_ENABLE.fll_enable)
      else $error("loop off while debugging");
endmodule : clock_source_checker

bind fll_clock_source_regs clock_source_checker u_chk (.CLOCK, .NRST, .READ, .WRITE,
   .WAITREQUEST, .INT_REF_TICK, .EXT_REF_TICK, .STOP_MODE, .DEBUG_ACTIVE,
   .FLL_REFERENCE_TICK, .INTERNAL_REFERENCE_OUT, .EXTERNAL_REFERENCE_OUT,
   .SOURCE_CLOCK_OUT, .BUS_CLOCK, .CLOCK_ENABLE);

// file: tb/clock_ref_model.sv
// Reference and loop tick source facing the clock source block
`timescale 1ns/10ps
module clock_ref_model #(
   parameter int INT_P = 3,
   parameter int EXT_P = 5
) (
   input wire logic clk, // System clock
   input wire logic nrst, // Reset, active low
   output logic int_tick, // Internal reference edge
   output logic ext_tick, // External reference edge
   output logic fll_tick // Loop output edge
);
   int ic;
   int ec;
   // Free running; keeping the divided rate in range is software's job
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ic <= 0;
         ec <= 0;
      end else begin
         ic <= (ic == INT_P - 1) ? 0 : ic + 1;
         ec <= (ec == EXT_P - 1) ? 0 : ec + 1;
      end
   end
   assign int_tick = nrst && (ic == 0);
   assign ext_tick = nrst && (ec == 0);
   // Loop ticks on every system clock edge, at the system clock rate
   assign fll_tick = nrst;
endmodule : clock_ref_model

// file: tb/fll_clock_source_regs_tb.sv
// Self-checking bench for the clock source register block
`timescale 1ns/10ps
module fll_clock_source_regs_tb;
   import clock_source_pkg::*;
   logic clock, nrst, rd, wr, stop, dbg, wreq, fref, iout, eout, sout, bclk, it, et, ft;
   logic [3:0] addr, be;
   logic [31:0] wdat, rdat, q;
   logic [8:0] trim;
   osc_ctrl_s osc;
   clock_enable_s cen;
   int miscompares, n_checks, n, k;
   int gs[4] = '{1, 3, 5, 1};
   logic [7:0] ss[4] = '{8'h01, 8'h05, 8'h09, 8'h01};
   wire [4:0] pul = {bclk, fref, iout, sout, eout};
   fll_clock_source_regs u_dut (.CLOCK(clock), .NRST(nrst), .ADDRESS(addr), .READ(rd),
      .WRITE(wr), .WRITEDATA(wdat), .BYTEENABLE(be), .READDATA(rdat), .WAITREQUEST(wreq),
      .INT_REF_TICK(it), .EXT_REF_TICK(et), .FLL_TICK(ft), .STOP_MODE(stop),
      .DEBUG_ACTIVE(dbg), .FLL_REFERENCE_TICK(fref), .INTERNAL_REFERENCE_OUT(iout),
      .EXTERNAL_REFERENCE_OUT(eout), .SOURCE_CLOCK_OUT(sout), .BUS_CLOCK(bclk),
      .OSC_CTRL(osc), .CLOCK_ENABLE(cen), .PERIOD_TRIM(trim));
   clock_ref_model u_ref (.clk(clock), .nrst(nrst), .int_tick(it), .ext_tick(et),
      .fll_tick(ft));
   always #4 clock = ~clock;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Request held until the edge that sees wait low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdat <= {24'h00_0000, d};
      do @(posedge clock); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h00_0000, e});
   endtask : rchk
   task automatic settle;
      repeat (3) @(negedge clock);
   endtask : settle
   // Third gap, so a deferred divider change has landed
   task automatic meas(input int s);
      repeat (3) begin
         @(negedge clock);
         while (pul[s] !== 1'b1) @(negedge clock);
         n = 0;
         do begin
            @(negedge clock);
            n++;
         end while (pul[s] !== 1'b1);
      end
   endtask : meas
   task automatic cnt(input int s);
      k = 0;
      repeat (30) begin
         @(negedge clock);
         k += (pul[s] === 1'b1);
      end
   endtask : cnt
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   initial begin
      #(8 * 40000);
      miscompares++;
      stop_test();
   end
   initial begin
      {clock, nrst, rd, wr, stop, dbg} = 6'h00;
      addr = 4'h0;
      be = 4'h1;
      wdat = 32'h0000_0000;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rchk(OFS_CONTROL_1, 8'h04);
      rchk(OFS_CONTROL_2, 8'h40);
      rchk(OFS_TRIM, 8'h80);
      rchk(OFS_STATUS, 8'h00);
      chk(trim, 9'h100);
      chk({cen.internal_enable, cen.fll_enable}, 2'h3);
      rchk(4'h2, 8'h00);
      be <= 4'h0;
      bus(1'b1, OFS_TRIM, 8'h11);
      be <= 4'h1;
      rchk(OFS_TRIM, 8'h80);
      bus(1'b1, OFS_TRIM, 8'h5A);
      bus(1'b1, OFS_STATUS, 8'h01);
      settle();
      chk(trim, 9'h0B5);
      rchk(OFS_STATUS, 8'h01);
      bus(1'b1, OFS_CONTROL_2, 8'h24);
      settle();
      chk(osc, 3'h5);
      bus(1'b1, OFS_CONTROL_2, 8'h10);
      settle();
      chk(osc, 3'h2);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_CONTROL_2, {i[1:0], 6'h00});
         meas(1);
         chk(n, 1 << i);
      end
      // Bus divider back to one, so a gap is one source period
      bus(1'b1, OFS_CONTROL_2, 8'h00);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_CONTROL_1, {i[1:0], 6'h04});
         meas(1);
         chk(n, gs[i]);
         rchk(OFS_STATUS, ss[i]);
      end
      cnt(4);
      chk(k, 15);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, OFS_CONTROL_1, {2'h0, i[2:0], 3'h4});
         meas(3);
         chk(n, 3 << i);
      end
      bus(1'b1, OFS_CONTROL_1, 8'h08);
      meas(3);
      chk(n, 10);
      cnt(2);
      chk(k, 0);
      cnt(0);
      chk(k, 0);
      bus(1'b1, OFS_CONTROL_1, 8'h07);
      bus(1'b1, OFS_CONTROL_2, 8'h43);
      cnt(2);
      chk(k, 10);
      cnt(0);
      chk(k, 6);
      @(posedge clock) stop <= 1'b1;
      settle();
      cnt(2);
      chk(k, 10);
      cnt(0);
      chk(k, 6);
      cnt(1);
      chk(k, 0);
      @(posedge clock) stop <= 1'b0;
      bus(1'b1, OFS_CONTROL_1, 8'h05);
      bus(1'b1, OFS_CONTROL_2, 8'h41);
      stop <= 1'b1;
      settle();
      chk({cen.internal_enable, cen.external_enable}, 2'h2);
      cnt(2);
      chk(k, 0);
      @(posedge clock) stop <= 1'b0;
      bus(1'b1, OFS_CONTROL_1, 8'h44);
      bus(1'b1, OFS_CONTROL_2, 8'h48);
      settle();
      chk(cen.fll_enable, 1'b0);
      @(posedge clock) dbg <= 1'b1;
      settle();
      chk(cen.fll_enable, 1'b1);
      stop_test();
   end
endmodule : fll_clock_source_regs_tb
